// ### rtl/agsc_params.svh
// Constants for the address generation and stack check block.
// Assumes inclusion by the package and the design file.
`ifndef AGSC_PARAMS_SVH
`define AGSC_PARAMS_SVH
`define AGSC_SP_FLOOR 16'h0800
`define AGSC_DIRECT_BITS 13
`define AGSC_LIT5_BITS 5
`define AGSC_LIT10_BITS 10
`define AGSC_LIT8_BITS 8
`define AGSC_LIT14_BITS 14
`define AGSC_SP_INDEX 4'hf
`define AGSC_DEF_REG_INDEX 4'h0
`define AGSC_XA_INDEX 4'h8
`define AGSC_XB_INDEX 4'h9
`define AGSC_YA_INDEX 4'ha
`define AGSC_YB_INDEX 4'hb
`define AGSC_SP_RESET 16'h0800
`endif

// ### rtl/agsc_pkg.sv
// Types for the address generation and stack check block.
// Assumes the params header sits beside it.
`include "agsc_params.svh"
package agsc_pkg;
	// Operand addressing modes
	typedef enum logic [3:0] {
		AGSC_DIRECT = 4'h0,
		AGSC_REG = 4'h1,
		AGSC_IND = 4'h2,
		AGSC_POST = 4'h3,
		AGSC_PRE = 4'h4,
		AGSC_REG_OFS = 4'h5,
		AGSC_LIT_OFS = 4'h6,
		AGSC_FILE = 4'h7,
		AGSC_LIT = 4'h8,
		AGSC_PUSH = 4'h9,
		AGSC_POP = 4'ha,
		AGSC_CALL = 4'hb,
		AGSC_EXC = 4'hc,
		AGSC_DSP = 4'hd
	} agsc_mode_e;
	// Instruction classes
	typedef enum logic [2:0] {
		AGSC_CL_FILE = 3'h0,
		AGSC_CL_MCU = 3'h1,
		AGSC_CL_MOVE = 3'h2,
		AGSC_CL_DSP = 3'h3,
		AGSC_CL_OTHER = 3'h4
	} agsc_class_e;
	// Decoded request from the instruction decoder
	typedef struct packed {
		logic valid;
		agsc_class_e iclass;
		agsc_mode_e mode;
		logic [3:0] ptr;
		logic [3:0] base;
		logic [15:0] lit;
		logic [2:0] lit_width;
		logic [1:0] dsp_step;
		logic dsp_idx;
		logic mod_dec;
		logic [1:0] mod_amt;
		logic is_dst;
	} agsc_req_s;
	// Generated address
	typedef struct packed {
		logic valid;
		logic [15:0] ea;
		logic y_space;
		logic wr_en;
		logic [15:0] wr_data;
		logic illegal;
	} agsc_ea_s;
endpackage : agsc_pkg

// ### rtl/agsc_core.sv
// Address generation and stack check core.
// Assumes decoder requests synchronous to clk_in, register file outside.
`timescale 1ns/10ps
`include "agsc_params.svh"
module agsc_core #(
	parameter int WIDTH = 16
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire agsc_pkg::agsc_req_s req_in,
	input wire logic [15:0] ptr_val_in,
	input wire logic [15:0] base_val_in,
	input wire logic [15:0] pc_in,
	input wire logic [7:0] status_low_byte_in,
	input wire logic limit_wr_in,
	input wire logic [15:0] limit_data_in,
	input wire logic protect_en_in,
	input wire logic from_boot_flash_in,
	input wire logic from_secure_flash_in,
	input wire logic [15:0] boot_protected_ram_lo_in,
	input wire logic [15:0] boot_protected_ram_hi_in,
	input wire logic [15:0] secure_segment_ram_lo_in,
	input wire logic [15:0] secure_segment_ram_hi_in,
	output agsc_pkg::agsc_ea_s ea_out,
	output logic [15:0] stack_pointer_reg_out,
	output logic [15:0] stack_limit_reg_out,
	output logic [15:0] literal_out,
	output logic [3:0] dst_reg_out,
	output logic stack_trap_out,
	output logic protect_fault_out
);
	import agsc_pkg::*;

	// ----------------------------------------------------------------
	// Stack state
	// ----------------------------------------------------------------
	logic [15:0] sp_q;
	logic [15:0] sp_d;
	logic [15:0] limit_q;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] step_of(input logic [1:0] amt);
		step_of = {13'h0000, amt, 1'b0};
	endfunction : step_of

	function automatic logic in_seg(input logic [15:0] a,
		input logic [15:0] lo, input logic [15:0] hi);
		in_seg = (a >= lo) && (a <= hi);
	endfunction : in_seg

	// Pointer source; stack pointer held here
	wire uses_sp = (req_in.ptr == `AGSC_SP_INDEX);
	wire [15:0] ptr_v = uses_sp ? sp_q : ptr_val_in;
	wire [15:0] step = step_of(req_in.mod_amt);
	wire [15:0] signed_step = req_in.mod_dec ? (16'h0000 - step) : step;

	// Literal widening for short literal fields
	wire [15:0] lit5 = {11'h000, req_in.lit[4:0]};
	wire [15:0] lit10 = {6'h00, req_in.lit[9:0]};
	wire [15:0] lit8 = {8'h00, req_in.lit[7:0]};
	wire [15:0] lit14 = {2'h0, req_in.lit[13:0]};
	wire [15:0] lit_sel =
		(req_in.lit_width == 3'h0) ? lit5 :
		(req_in.lit_width == 3'h1) ? lit10 :
		(req_in.lit_width == 3'h2) ? lit8 :
		(req_in.lit_width == 3'h3) ? lit14 :
		req_in.lit;

	// Direct file address, 13-bit field
	wire [15:0] file_ea = {3'h0, req_in.lit[`AGSC_DIRECT_BITS-1:0]};

	// DSP prefetch legality and space
	wire dsp_reg_ok = (req_in.ptr >= `AGSC_XA_INDEX) &&
		(req_in.ptr <= `AGSC_YB_INDEX);
	wire dsp_idx_ok = (req_in.ptr == `AGSC_XB_INDEX) ||
		(req_in.ptr == `AGSC_YB_INDEX);
	wire dsp_y = (req_in.ptr == `AGSC_YA_INDEX) ||
		(req_in.ptr == `AGSC_YB_INDEX);
	wire dsp_step_ok = (req_in.dsp_step != 2'h3);
	wire [15:0] dsp_ea = req_in.dsp_idx ? (ptr_v + base_val_in) : ptr_v;
	wire dsp_bad = !dsp_reg_ok || (req_in.dsp_idx && !dsp_idx_ok) ||
		!dsp_step_ok;

	// Indexed mode only for the move class
	wire idx_bad = (req_in.mode == AGSC_REG_OFS) &&
		(req_in.iclass != AGSC_CL_MOVE);

	// Effective address per mode
	logic [15:0] ea_c;
	always_comb begin
		case (req_in.mode)
			AGSC_IND: ea_c = ptr_v;
			AGSC_POST: ea_c = ptr_v;
			AGSC_PRE: ea_c = ptr_v + signed_step;
			AGSC_REG_OFS: ea_c = ptr_v + base_val_in;
			AGSC_LIT_OFS: ea_c = ptr_v + lit_sel;
			AGSC_FILE: ea_c = file_ea;
			AGSC_PUSH: ea_c = sp_q;
			AGSC_CALL: ea_c = sp_q;
			AGSC_EXC: ea_c = sp_q;
			AGSC_POP: ea_c = sp_q - 16'h0002;
			AGSC_DSP: ea_c = dsp_ea;
			default: ea_c = 16'h0000;
		endcase
	end

	// Pointer write-back for modify modes and stack moves
	wire is_push = (req_in.mode == AGSC_PUSH) ||
		(req_in.mode == AGSC_CALL) || (req_in.mode == AGSC_EXC);
	wire is_pop = (req_in.mode == AGSC_POP);
	wire [15:0] dsp_next = ptr_v + step_of(req_in.dsp_step + 2'h1);
	wire [15:0] post_next = ptr_v + signed_step;
	wire sp_mod = req_in.valid && uses_sp &&
		((req_in.mode == AGSC_POST) || (req_in.mode == AGSC_PRE));
	always_comb begin
		sp_d = sp_q;
		if (req_in.valid && is_push) begin
			sp_d = sp_q + 16'h0002;
		end else if (req_in.valid && is_pop) begin
			sp_d = sp_q - 16'h0002;
		end else if (sp_mod) begin
			sp_d = (req_in.mode == AGSC_PRE) ? ea_c : post_next;
		end
	end

	// Stacked word for calls and exceptions
	wire [15:0] call_word = {1'b0, pc_in[14:0]};
	wire [15:0] exc_word = {status_low_byte_in, pc_in[7:0]};

	// Stack limit and floor checks on every stack address
	wire sp_addr = req_in.valid && (uses_sp || is_push || is_pop);
	wire over = sp_addr && (ea_c > limit_q);
	wire under = sp_addr && (ea_c < `AGSC_SP_FLOOR);
	wire trap_c = over || under;

	// Protected segment check
	wire in_boot = in_seg(ea_c, boot_protected_ram_lo_in,
		boot_protected_ram_hi_in);
	wire in_sec = in_seg(ea_c, secure_segment_ram_lo_in,
		secure_segment_ram_hi_in);
	wire prot_c = req_in.valid && protect_en_in &&
		((in_boot && !from_boot_flash_in) ||
		(in_sec && !from_secure_flash_in));

	// Destination register for file instructions
	wire [3:0] dst_c = (req_in.iclass == AGSC_CL_FILE && req_in.is_dst) ?
		`AGSC_DEF_REG_INDEX : req_in.base;

	wire ill_c = (req_in.mode == AGSC_DSP && dsp_bad) || idx_bad;
	wire y_c = (req_in.mode == AGSC_DSP) && dsp_y;
	wire wr_c = req_in.valid && is_push;
	wire [15:0] wd_c = (req_in.mode == AGSC_CALL) ? call_word :
		(req_in.mode == AGSC_EXC) ? exc_word : ptr_val_in;
	wire [15:0] pb_c = (req_in.mode == AGSC_DSP) ? dsp_next : post_next;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Stack pointer
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			sp_q <= `AGSC_SP_RESET;
		end else begin
			sp_q <= sp_d;
		end
	end

	// Stack limit: no reset value, bit 0 forced low
	always_ff @(posedge clk_in) begin
		if (limit_wr_in) begin
			limit_q <= {limit_data_in[15:1], 1'b0};
		end
	end

	// Address and status outputs
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			ea_out <= '0;
			literal_out <= 16'h0000;
			dst_reg_out <= 4'h0;
			stack_trap_out <= 1'b0;
			protect_fault_out <= 1'b0;
			stack_pointer_reg_out <= `AGSC_SP_RESET;
			stack_limit_reg_out <= 16'h0000;
		end else begin
			ea_out.valid <= req_in.valid;
			ea_out.ea <= ea_c;
			ea_out.y_space <= y_c;
			ea_out.wr_en <= wr_c;
			ea_out.wr_data <= ((req_in.mode == AGSC_POST) ||
				(req_in.mode == AGSC_DSP)) ? pb_c : wd_c;
			ea_out.illegal <= req_in.valid && ill_c;
			literal_out <= lit_sel;
			dst_reg_out <= dst_c;
			stack_trap_out <= trap_c;
			protect_fault_out <= prot_c;
			stack_pointer_reg_out <= sp_d;
			stack_limit_reg_out <= limit_q;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Stack movement, limit and floor
	push_step_a: assert property (@(posedge clk_in)
		disable iff (!nrst_in)
		req_in.valid && (req_in.mode == AGSC_PUSH) |=>
		stack_pointer_reg_out == $past(sp_q) + 16'h0002)
		else $error("push did not advance stack pointer");
	pop_step_a: assert property (@(posedge clk_in)
		disable iff (!nrst_in)
		req_in.valid && is_pop |=>
		ea_out.ea == $past(sp_q) - 16'h0002)
		else $error("pop address not pre-decremented");
	pop_sp_a: assert property (@(posedge clk_in)
		disable iff (!nrst_in)
		req_in.valid && is_pop |=>
		stack_pointer_reg_out == $past(sp_q) - 16'h0002)
		else $error("pop did not lower stack pointer");
	push_addr_a: assert property (@(posedge clk_in)
		disable iff (!nrst_in)
		req_in.valid && is_push |=>
		(ea_out.ea == $past(sp_q)) && ea_out.wr_en)
		else $error("push not written at stack pointer");
	limit_align_a: assert property (@(posedge clk_in)
		disable iff (!nrst_in)
		limit_wr_in |=> ##1 !stack_limit_reg_out[0])
		else $error("stack limit bit 0 set");
	limit_low_a: assert property (@(posedge clk_in)
		disable iff (!nrst_in)
		limit_wr_in |=> !limit_q[0])
		else $error("stored stack limit bit 0 set");
	limit_equal_a: assert property (@(posedge clk_in)
		disable iff (!nrst_in)
		req_in.valid && is_push && (sp_q == limit_q) &&
		(sp_q >= 16'h0800) |=> !stack_trap_out)
		else $error("push at limit trapped");
	limit_over_a: assert property (@(posedge clk_in)
		disable iff (!nrst_in)
		req_in.valid && is_push && (sp_q > limit_q) |=>
		stack_trap_out)
		else $error("push beyond limit not trapped");
	floor_trap_a: assert property (@(posedge clk_in)
		disable iff (!nrst_in)
		req_in.valid && is_push && (sp_q < 16'h0800) |=>
		stack_trap_out)
		else $error("underflow not trapped");
	sp_floor_a: assert property (@(posedge clk_in)
		disable iff (!nrst_in)
		req_in.valid && uses_sp && (ea_c < 16'h0800) |=>
		stack_trap_out)
		else $error("stack address below floor not trapped");
	trap_quiet_a: assert property (@(posedge clk_in)
		disable iff (!nrst_in)
		!(req_in.valid && (uses_sp || is_push || is_pop)) |=>
		!stack_trap_out)
		else $error("trap raised without stack address");

	// Stacked program counter words
	call_msb_a: assert property (@(posedge clk_in)
		disable iff (!nrst_in)
		req_in.valid && (req_in.mode == AGSC_CALL) |=>
		!ea_out.wr_data[15])
		else $error("call word top bit set");
	call_word_a: assert property (@(posedge clk_in)
		disable iff (!nrst_in)
		req_in.valid && (req_in.mode == AGSC_CALL) |=>
		ea_out.wr_data == ($past(pc_in) & 16'h7fff))
		else $error("call word differs from program counter");
	exc_byte_a: assert property (@(posedge clk_in)
		disable iff (!nrst_in)
		req_in.valid && (req_in.mode == AGSC_EXC) |=>
		ea_out.wr_data[15:8] == $past(status_low_byte_in))
		else $error("status byte missing in stacked word");
	exc_pc_a: assert property (@(posedge clk_in)
		disable iff (!nrst_in)
		req_in.valid && (req_in.mode == AGSC_EXC) |=>
		{8'h00, ea_out.wr_data[7:0]} == ($past(pc_in) & 16'h00ff))
		else $error("program counter missing in stacked word");

	// Operand forms
	file_range_a: assert property (@(posedge clk_in)
		disable iff (!nrst_in)
		req_in.valid && (req_in.mode == AGSC_FILE) |=>
		ea_out.ea < 16'h2000)
		else $error("file address beyond 8192 bytes");
	file_dst_a: assert property (@(posedge clk_in)
		disable iff (!nrst_in)
		req_in.valid && (req_in.iclass == AGSC_CL_FILE) &&
		req_in.is_dst |=> dst_reg_out == 4'h0)
		else $error("file result not sent to default register");
	lit_short_a: assert property (@(posedge clk_in)
		disable iff (!nrst_in)
		req_in.lit_width == 3'h0 |=>
		literal_out[15:5] == 11'h000)
		else $error("short literal wider than five bits");
	idx_class_a: assert property (@(posedge clk_in)
		disable iff (!nrst_in)
		req_in.valid && (req_in.mode == AGSC_REG_OFS) &&
		(req_in.iclass != AGSC_CL_MOVE) |=> ea_out.illegal)
		else $error("indexed mode accepted outside move class");

	// Prefetch spaces and protection
	dsp_space_a: assert property (@(posedge clk_in)
		disable iff (!nrst_in)
		req_in.valid && (req_in.mode == AGSC_DSP) &&
		(req_in.ptr == 4'h8) |=> !ea_out.y_space)
		else $error("X prefetch sent to Y space");
	dsp_space_y_a: assert property (@(posedge clk_in)
		disable iff (!nrst_in)
		req_in.valid && (req_in.mode == AGSC_DSP) &&
		(req_in.ptr == 4'hb) |=> ea_out.y_space)
		else $error("Y prefetch sent to X space");
	dsp_index_a: assert property (@(posedge clk_in)
		disable iff (!nrst_in)
		req_in.valid && (req_in.mode == AGSC_DSP) && req_in.dsp_idx &&
		(req_in.ptr == 4'ha) |=> ea_out.illegal)
		else $error("indexed prefetch via wrong register");
	dsp_step_a: assert property (@(posedge clk_in)
		disable iff (!nrst_in)
		req_in.valid && (req_in.mode == AGSC_DSP) &&
		(req_in.dsp_step == 2'h3) |=> ea_out.illegal)
		else $error("reserved prefetch step accepted");
	protect_a: assert property (@(posedge clk_in)
		disable iff (!nrst_in)
		prot_c |=> protect_fault_out)
		else $error("protected segment access not flagged");
	prot_off_a: assert property (@(posedge clk_in)
		disable iff (!nrst_in)
		!protect_en_in |=> !protect_fault_out)
		else $error("fault flagged with protection off");
endmodule : agsc_core

// ### dv/agsc_regfile_model.sv
// Working register file model facing the address generation core.
// Assumes register indices from the bench; values feed pointer and base.
`timescale 1ns/10ps
module agsc_regfile_model (
	input wire logic [3:0] ptr_idx_in,
	input wire logic [3:0] base_idx_in,
	output logic [15:0] ptr_val_out,
	output logic [15:0] base_val_out
);
	// Fixed contents derived from the index, distinct per register
	assign ptr_val_out = {4'h1, ptr_idx_in, 8'h00};
	assign base_val_out = {8'h00, base_idx_in, 4'h0};
endmodule : agsc_regfile_model

// ### dv/tb_top.sv
// Self-checking bench for the address generation and stack check core.
// Assumes the register file model and the agsc package are compiled first.
`timescale 1ns/10ps
module tb_top;
	import agsc_pkg::*;
	logic clk_in, nrst_in, lwr, prot, fboot, fsec;
	logic [15:0] pc, ldata, pv, bv, sp, lim, lit_o, s, l, esp;
	logic [15:0] xs [5];
	logic [7:0] stat_lo;
	logic [3:0] dr, d;
	logic trap, fault, t, f;
	agsc_req_s req, rq;
	agsc_ea_s ea, e;
	int miscompares, total_checks;
	agsc_regfile_model agsc_regfile_model_i (.ptr_idx_in(req.ptr),
		.base_idx_in(req.base), .ptr_val_out(pv), .base_val_out(bv));
	agsc_core agsc_core_i (.clk_in(clk_in), .nrst_in(nrst_in),
		.req_in(req), .ptr_val_in(pv), .base_val_in(bv), .pc_in(pc),
		.status_low_byte_in(stat_lo), .limit_wr_in(lwr),
		.limit_data_in(ldata), .protect_en_in(prot),
		.from_boot_flash_in(fboot), .from_secure_flash_in(fsec),
		.boot_protected_ram_lo_in(16'h1200),
		.boot_protected_ram_hi_in(16'h12ff),
		.secure_segment_ram_lo_in(16'h1100),
		.secure_segment_ram_hi_in(16'h11ff), .ea_out(ea),
		.stack_pointer_reg_out(sp), .stack_limit_reg_out(lim),
		.literal_out(lit_o), .dst_reg_out(dr), .stack_trap_out(trap),
		.protect_fault_out(fault));
	//--------------------------------
	// Clock and common tasks
	//--------------------------------
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] x);
		total_checks++;
		if (g !== x) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, g, x);
		end
	endtask : chk
	task automatic chk_b(input logic g, input logic x);
		chk({15'h0, g}, {15'h0, x});
	endtask : chk_b
	// One request, outputs captured in the answer cycle
	task automatic go(input agsc_mode_e m, input logic [3:0] p);
		agsc_req_s r;
		r = rq;
		r.valid = 1'b1;
		r.mode = m;
		r.ptr = p;
		req = r;
		@(posedge clk_in);
		#1;
		e = ea;
		t = trap;
		f = fault;
		l = lit_o;
		s = sp;
		d = dr;
		req.valid = 1'b0;
		@(posedge clk_in);
		#1;
	endtask : go
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : test_done
	//--------------------------------
	// Scenarios
	//--------------------------------
	task automatic t_stack();
		lwr = 1'b1;
		ldata = 16'h0805;
		@(posedge clk_in);
		#1;
		lwr = 1'b0;
		@(posedge clk_in);
		#1;
		chk(lim, 16'h0804);
		esp = 16'h0800;
		for (int i = 0; i < 4; i++) begin
			go(AGSC_PUSH, 4'hf);
			chk(e.ea, esp);
			chk_b(e.wr_en, 1'b1);
			chk(e.wr_data, 16'h1f00);
			chk(s, esp + 16'h0002);
			chk_b(t, esp > 16'h0804);
			esp = esp + 16'h0002;
		end
		for (int i = 0; i < 5; i++) begin
			esp = esp - 16'h0002;
			go(AGSC_POP, 4'hf);
			chk(e.ea, esp);
			chk(s, esp);
			chk_b(t, esp > 16'h0804 || esp < 16'h0800);
		end
	endtask : t_stack
	task automatic t_pcstack();
		pc = 16'hffff;
		stat_lo = 8'ha5;
		go(AGSC_CALL, 4'hf);
		chk_b(e.wr_data[15], 1'b0);
		chk(e.wr_data, 16'h7fff);
		go(AGSC_EXC, 4'hf);
		chk(e.wr_data, 16'ha5ff);
	endtask : t_pcstack
	task automatic t_modes();
		rq = '0;
		rq.iclass = AGSC_CL_MOVE;
		rq.base = 4'h2;
		rq.lit = 16'h0040;
		rq.mod_amt = 2'h1;
		rq.lit_width = 3'h2;
		go(AGSC_IND, 4'h3);
		chk(e.ea, 16'h1300);
		chk_b(e.valid, 1'b1);
		go(AGSC_REG_OFS, 4'h3);
		chk(e.ea, 16'h1320);
		go(AGSC_LIT_OFS, 4'h3);
		chk(e.ea, 16'h1340);
		go(AGSC_POST, 4'h3);
		chk(e.ea, 16'h1300);
		chk(e.wr_data, 16'h1302);
		rq.mod_dec = 1'b1;
		go(AGSC_PRE, 4'h3);
		chk(e.ea, 16'h12fe);
		rq.iclass = AGSC_CL_MCU;
		go(AGSC_REG_OFS, 4'h3);
		chk_b(e.illegal, 1'b1);
	endtask : t_modes
	task automatic t_dsp();
		rq = '0;
		rq.iclass = AGSC_CL_DSP;
		for (int p = 8; p < 12; p++) begin
			go(AGSC_DSP, 4'(p));
			chk_b(e.y_space, p > 9);
			chk_b(e.illegal, 1'b0);
		end
		go(AGSC_DSP, 4'h5);
		chk_b(e.illegal, 1'b1);
		rq.dsp_idx = 1'b1;
		go(AGSC_DSP, 4'h8);
		chk_b(e.illegal, 1'b1);
		go(AGSC_DSP, 4'hb);
		chk_b(e.illegal, 1'b0);
		rq.dsp_idx = 1'b0;
		rq.dsp_step = 2'h2;
		go(AGSC_DSP, 4'ha);
		chk(e.wr_data, 16'h1a06);
		rq.dsp_step = 2'h3;
		go(AGSC_DSP, 4'ha);
		chk_b(e.illegal, 1'b1);
	endtask : t_dsp
	task automatic t_lit_file();
		xs = '{16'h001f, 16'h03ff, 16'h00ff, 16'h3fff, 16'hffff};
		rq = '0;
		rq.lit = 16'hffff;
		for (int w = 0; w < 5; w++) begin
			rq.lit_width = 3'(w);
			go(AGSC_LIT, 4'h0);
			chk(l, xs[w]);
		end
		rq.iclass = AGSC_CL_FILE;
		rq.is_dst = 1'b1;
		rq.base = 4'h7;
		go(AGSC_FILE, 4'h0);
		chk(e.ea, 16'h1fff);
		chk({12'h0, d}, 16'h0000);
		rq.is_dst = 1'b0;
		go(AGSC_FILE, 4'h0);
		chk({12'h0, d}, 16'h0007);
	endtask : t_lit_file
	task automatic t_prot();
		rq = '0;
		prot = 1'b1;
		go(AGSC_IND, 4'h1);
		chk_b(f, 1'b1);
		fsec = 1'b1;
		go(AGSC_IND, 4'h1);
		chk_b(f, 1'b0);
		go(AGSC_IND, 4'h2);
		chk_b(f, 1'b1);
		fboot = 1'b1;
		go(AGSC_IND, 4'h2);
		chk_b(f, 1'b0);
	endtask : t_prot
	// Watchdog against a stuck run
	initial begin
		#100000;
		miscompares++;
		test_done();
	end
	// Main sequence
	initial begin
		{lwr, prot, fboot, fsec, stat_lo} = '0;
		{pc, ldata} = '0;
		rq = '0;
		req = '0;
		miscompares = 0;
		total_checks = 0;
		nrst_in = 1'b0;
		repeat (2) @(posedge clk_in);
		#1;
		nrst_in = 1'b1;
		chk(sp, 16'h0800);
		chk_b(trap, 1'b0);
		t_stack();
		t_pcstack();
		t_modes();
		t_dsp();
		t_lit_file();
		t_prot();
		test_done();
	end
endmodule : tb_top
